// [include/operand_decoder_defines.svh]
// Purpose: Constants for the operand descriptor decoder
// Assumes: Descriptor byte is mode nibble over register-select nibble
// Notes: Shared by the package and both design modules
`ifndef OPERAND_DECODER_DEFINES_SVH
`define OPERAND_DECODER_DEFINES_SVH

// Descriptor field positions
`define ODD_MODE_HI 7
`define ODD_MODE_LO 4
`define ODD_RSEL_HI 3
`define ODD_RSEL_LO 0

// Mode field values
`define ODD_MODE_REG 4'h4
`define ODD_MODE_REGDEF 4'h5
`define ODD_MODE_FPOFF 4'h6
`define ODD_MODE_APOFF 4'h7
`define ODD_MODE_WDISP 4'h8
`define ODD_MODE_WDISPD 4'h9
`define ODD_MODE_HDISP 4'ha
`define ODD_MODE_HDISPD 4'hb
`define ODD_MODE_BDISP 4'hc
`define ODD_MODE_BDISPD 4'hd
`define ODD_MODE_EXP 4'he
`define ODD_MODE_NLIT 4'hf

// Special register numbers
`define ODD_RSEL_ESC 4'hf
`define ODD_REG_FP 4'h9
`define ODD_REG_AP 4'ha

// Trailing data lengths in bytes
`define ODD_LEN_NONE 3'h0
`define ODD_LEN_B 3'h1
`define ODD_LEN_H 3'h2
`define ODD_LEN_W 3'h4

// Reset values
`define ODD_RST_WORD 32'h0000_0000

`endif

// [include/operand_decoder_pkg.sv]
// Purpose: Types and shared decode functions for the operand decoder
// Assumes: Defines header is on the include path
// Notes: No constants here; numbers live in the defines header
`include "operand_decoder_defines.svh"

package operand_decoder_pkg;

  // Gray along idle, descriptor, data, calc, pointer, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DESC = 3'h1,
    ST_DATA = 3'h3,
    ST_CALC = 3'h2,
    ST_PTR = 3'h6,
    ST_DONE = 3'h7
  } state_e;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_REG = 2'h1,
    K_IMM = 2'h2,
    K_MEM = 2'h3
  } kind_e;

  // Count of data bytes that follow a descriptor
  function automatic logic [2:0] data_bytes(input logic [7:0] d);
    logic esc;
    esc = (d[3:0] == `ODD_RSEL_ESC);
    case (d[7:4])
      `ODD_MODE_REG, `ODD_MODE_APOFF: data_bytes = esc ? `ODD_LEN_W : `ODD_LEN_NONE;
      `ODD_MODE_REGDEF: data_bytes = esc ? `ODD_LEN_H : `ODD_LEN_NONE;
      `ODD_MODE_FPOFF: data_bytes = esc ? `ODD_LEN_B : `ODD_LEN_NONE;
      `ODD_MODE_EXP: data_bytes = esc ? `ODD_LEN_W : `ODD_LEN_NONE;
      `ODD_MODE_WDISP, `ODD_MODE_WDISPD: data_bytes = `ODD_LEN_W;
      `ODD_MODE_HDISP, `ODD_MODE_HDISPD: data_bytes = `ODD_LEN_H;
      `ODD_MODE_BDISP, `ODD_MODE_BDISPD: data_bytes = `ODD_LEN_B;
      default: data_bytes = `ODD_LEN_NONE;
    endcase
  endfunction : data_bytes

  // Pointer modes: displacement deferred and absolute deferred
  function automatic logic is_deferred(input logic [7:0] d);
    is_deferred = (d[7:4] == `ODD_MODE_WDISPD) || (d[7:4] == `ODD_MODE_HDISPD) ||
                  (d[7:4] == `ODD_MODE_BDISPD) ||
                  ((d[7:4] == `ODD_MODE_EXP) && (d[3:0] == `ODD_RSEL_ESC));
  endfunction : is_deferred

  // Type-override prefix, not an operand in itself
  function automatic logic is_expanded(input logic [7:0] d);
    is_expanded = (d[7:4] == `ODD_MODE_EXP) && (d[3:0] != `ODD_RSEL_ESC);
  endfunction : is_expanded

  // Two's complement widening of byte and halfword fields
  function automatic logic [31:0] sign_ext(input logic [31:0] w, input logic [2:0] len);
    if (len == `ODD_LEN_B) begin
      sign_ext = {{24{w[7]}}, w[7:0]};
    end else if (len == `ODD_LEN_H) begin
      sign_ext = {{16{w[15]}}, w[15:0]};
    end else begin
      sign_ext = w;
    end
  endfunction : sign_ext

endpackage : operand_decoder_pkg

// [rtl/byte_assembler.sv]
// Purpose: Gathers trailing operand bytes into a widened word
// Assumes: At most four bytes per operand, lowest address first
// Notes: Output is combinational from the held bytes
`timescale 1ns/100ps
`default_nettype none
`include "operand_decoder_defines.svh"

module byte_assembler #(
  parameter int WORD_W = 32
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic load_in,
  input wire logic [7:0] byte_in,
  input wire logic [2:0] len_in,
  output logic [31:0] word_out
);

  logic [WORD_W-1:0] word;
  logic [1:0] idx;

  // Index arithmetic assumes exactly four byte lanes
  if (WORD_W != 32) begin : g_bad_width
    $error("byte_assembler supports only a 32-bit word");
  end

  // First byte lands in the low lane
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || clear_in) begin
      word <= `ODD_RST_WORD;
      idx <= 2'h0;
    end else if (load_in) begin
      word[{idx, 3'b000} +: 8] <= byte_in; // [RQ12]
      idx <= idx + 2'h1;
    end
  end

  // Short fields are signed, so widen before any add
  assign word_out = operand_decoder_pkg::sign_ext(word, len_in); // [RQ8]

endmodule : byte_assembler

`default_nettype wire

// [rtl/operand_decoder.sv]
// Purpose: Decodes one operand descriptor and locates the operand
// Assumes: Register file answers reg_data_in combinationally from reg_sel_out
// Notes: One operand per start; expanded prefix is folded into the same run
`timescale 1ns/100ps
`default_nettype none
`include "operand_decoder_defines.svh"

// Operation
// RQ1: Low descriptor nibble selects register 0 to 15.
// RQ2: High descriptor nibble is the addressing-mode number.
// RQ3: Register-select 15 gives the mode an alternative meaning.
// RQ4: Operands flagged as descriptor-less consume no bytes.
// RQ5: Mode 4 with register 0 to 14 yields the register contents.
// RQ6: Mode 5 uses the selected register as operand address.
// RQ7: Modes 8, 10, 12 add word, halfword, byte displacement to register.
// RQ8: Byte and halfword displacements are sign-extended to 32 bits.
// RQ9: Modes 6 and 7 add the short offset to frame or argument pointer.
// RQ10: Modes 9, 11, 13 fetch a pointer word at the displacement address.
// RQ11: Escape register with modes 4, 5, 6 gives 32, 16, 8-bit immediates.
// RQ12: Multi-byte stream values assemble least significant byte first.
// RQ13: Short literals 0 to 63 and -1 to -16 come from the descriptor.
// RQ14: Mode 7 with escape register takes a 32-bit absolute address.
// RQ15: Mode 14 with escape register fetches the operand address indirectly.
// RQ16: Modes 0 to 3 form unsigned 6-bit literal; mode 15 negative literal.
// RQ17: Mode 14 with other registers is the expanded-operand type prefix.
// RQ18: Total instruction bytes consumed per operand are reported.
module operand_decoder #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic no_desc_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic byte_ready_out,
  output logic [3:0] reg_sel_out,
  input wire logic [31:0] reg_data_in,
  output logic mem_rd_out,
  output logic [31:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_data_in,
  output logic done_out,
  output logic [1:0] kind_out,
  output logic [31:0] value_out,
  output logic [2:0] bytes_used_out,
  output logic expanded_out,
  output logic [3:0] type_out
);

  operand_decoder_pkg::state_e state, next_state;
  logic [7:0] desc;
  logic [2:0] remaining;
  logic [2:0] data_len;
  logic [2:0] used;
  logic [31:0] asm_word;
  logic [31:0] calc;
  operand_decoder_pkg::kind_e calc_kind;
  logic take;
  logic [3:0] mode;
  logic [3:0] rsel;
  logic esc;

  // Address arithmetic is fixed at one 32-bit word
  if (ADDR_W != 32) begin : g_bad_addr
    $error("operand_decoder supports only 32-bit addresses");
  end

  assign take = byte_valid_in && byte_ready_out;
  assign mode = desc[`ODD_MODE_HI:`ODD_MODE_LO]; // [RQ2]
  assign rsel = desc[`ODD_RSEL_HI:`ODD_RSEL_LO]; // [RQ1]
  assign esc = (rsel == `ODD_RSEL_ESC); // [RQ3]

  // Sequencing over descriptor, data bytes, address and pointer
  always_comb begin
    next_state = state;
    unique case (state)
      operand_decoder_pkg::ST_IDLE: begin
        if (start_in) begin
          next_state = no_desc_in ? operand_decoder_pkg::ST_DONE
                                  : operand_decoder_pkg::ST_DESC; // [RQ4]
        end
      end
      operand_decoder_pkg::ST_DESC: begin
        if (take) begin
          if (operand_decoder_pkg::is_expanded(byte_in)) begin
            next_state = operand_decoder_pkg::ST_DESC; // [RQ17]
          end else if (operand_decoder_pkg::data_bytes(byte_in) != `ODD_LEN_NONE) begin
            next_state = operand_decoder_pkg::ST_DATA;
          end else begin
            next_state = operand_decoder_pkg::ST_CALC;
          end
        end
      end
      operand_decoder_pkg::ST_DATA: begin
        if (take && remaining == 3'h1) begin
          next_state = operand_decoder_pkg::ST_CALC;
        end
      end
      operand_decoder_pkg::ST_CALC: begin
        next_state = operand_decoder_pkg::is_deferred(desc) ? operand_decoder_pkg::ST_PTR
                                                            : operand_decoder_pkg::ST_DONE;
      end
      operand_decoder_pkg::ST_PTR: begin
        if (mem_ack_in) begin
          next_state = operand_decoder_pkg::ST_DONE;
        end
      end
      operand_decoder_pkg::ST_DONE: begin
        next_state = operand_decoder_pkg::ST_IDLE;
      end
      default: begin
        next_state = operand_decoder_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= operand_decoder_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready follows the next state so the port stays a flop
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      byte_ready_out <= 1'b0;
    end else begin
      byte_ready_out <= (next_state == operand_decoder_pkg::ST_DESC) ||
                        (next_state == operand_decoder_pkg::ST_DATA);
    end
  end

  // Descriptor capture and trailing byte countdown
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      desc <= 8'h00;
      remaining <= `ODD_LEN_NONE;
      data_len <= `ODD_LEN_NONE;
    end else if (state == operand_decoder_pkg::ST_DESC && take) begin
      desc <= byte_in;
      remaining <= operand_decoder_pkg::data_bytes(byte_in); // [RQ11] [RQ14]
      data_len <= operand_decoder_pkg::data_bytes(byte_in);
    end else if (state == operand_decoder_pkg::ST_DATA && take) begin
      remaining <= remaining - 3'h1;
    end
  end

  // Expanded prefix: keep the new type for the real descriptor
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      expanded_out <= 1'b0;
      type_out <= 4'h0;
    end else if (state == operand_decoder_pkg::ST_IDLE && start_in) begin
      expanded_out <= 1'b0;
      type_out <= 4'h0;
    end else if (state == operand_decoder_pkg::ST_DESC && take &&
                 operand_decoder_pkg::is_expanded(byte_in)) begin
      expanded_out <= 1'b1; // [RQ17]
      type_out <= byte_in[`ODD_RSEL_HI:`ODD_RSEL_LO];
    end
  end

  // Base register choice; frame and argument pointer modes name it implicitly
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_sel_out <= 4'h0;
    end else if (state == operand_decoder_pkg::ST_DESC && take) begin
      if (byte_in[7:4] == `ODD_MODE_FPOFF) begin
        reg_sel_out <= `ODD_REG_FP; // [RQ9]
      end else if (byte_in[7:4] == `ODD_MODE_APOFF) begin
        reg_sel_out <= `ODD_REG_AP; // [RQ9]
      end else begin
        reg_sel_out <= byte_in[3:0]; // [RQ1]
      end
    end
  end

  // Stream bytes, cleared per operand
  byte_assembler #(
    .WORD_W(32)
  ) u_asm (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(state == operand_decoder_pkg::ST_IDLE),
    .load_in(state == operand_decoder_pkg::ST_DATA && take),
    .byte_in(byte_in),
    .len_in(data_len),
    .word_out(asm_word)
  );

  // Operand value or address from mode and register-select
  always_comb begin
    calc = `ODD_RST_WORD;
    calc_kind = operand_decoder_pkg::K_MEM;
    case (mode)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        calc = {26'h0, mode[1:0], rsel}; // [RQ16] [RQ13]
        calc_kind = operand_decoder_pkg::K_IMM;
      end
      `ODD_MODE_NLIT: begin
        calc = {{24{1'b1}}, desc}; // [RQ16] [RQ13]
        calc_kind = operand_decoder_pkg::K_IMM;
      end
      `ODD_MODE_REG, `ODD_MODE_REGDEF: begin
        calc = esc ? asm_word : reg_data_in; // [RQ5] [RQ6] [RQ11]
        calc_kind = esc ? operand_decoder_pkg::K_IMM :
                    (mode == `ODD_MODE_REG) ? operand_decoder_pkg::K_REG
                                            : operand_decoder_pkg::K_MEM;
      end
      `ODD_MODE_FPOFF: begin
        calc = esc ? asm_word : reg_data_in + {28'h0, rsel}; // [RQ9] [RQ11]
        calc_kind = esc ? operand_decoder_pkg::K_IMM : operand_decoder_pkg::K_MEM;
      end
      `ODD_MODE_APOFF: begin
        calc = esc ? asm_word : reg_data_in + {28'h0, rsel}; // [RQ9] [RQ14]
      end
      `ODD_MODE_EXP: begin
        calc = asm_word; // [RQ15]
      end
      default: begin
        calc = reg_data_in + asm_word; // [RQ7] [RQ10]
      end
    endcase
  end

  // Result holds address or value; pointer fetch replaces it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      value_out <= `ODD_RST_WORD;
      kind_out <= operand_decoder_pkg::K_NONE;
    end else if (state == operand_decoder_pkg::ST_IDLE && start_in && no_desc_in) begin
      value_out <= `ODD_RST_WORD;
      kind_out <= operand_decoder_pkg::K_NONE; // [RQ4]
    end else if (state == operand_decoder_pkg::ST_CALC) begin
      value_out <= calc;
      kind_out <= calc_kind;
    end else if (state == operand_decoder_pkg::ST_PTR && mem_ack_in) begin
      value_out <= mem_data_in; // [RQ10] [RQ15]
    end
  end

  // Pointer read held until acknowledged
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_rd_out <= 1'b0;
      mem_addr_out <= `ODD_RST_WORD;
    end else if (state == operand_decoder_pkg::ST_CALC &&
                 operand_decoder_pkg::is_deferred(desc)) begin
      mem_rd_out <= 1'b1; // [RQ10] [RQ15]
      mem_addr_out <= calc;
    end else if (mem_ack_in) begin
      mem_rd_out <= 1'b0;
    end
  end

  // Byte count includes descriptor, prefix and trailing bytes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || (state == operand_decoder_pkg::ST_IDLE && start_in)) begin
      used <= 3'h0;
    end else if (take) begin
      used <= used + 3'h1; // [RQ18]
    end
  end

  // Completion strobe and count, one cycle each operand
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      done_out <= 1'b0;
      bytes_used_out <= 3'h0;
    end else begin
      done_out <= (next_state == operand_decoder_pkg::ST_DONE);
      // Count clears on the same edge as a descriptor-less start
      if (next_state == operand_decoder_pkg::ST_DONE) begin
        bytes_used_out <= (state == operand_decoder_pkg::ST_IDLE) ? 3'h0 : used; // [RQ18] [RQ4]
      end
    end
  end

  property p_lit_pos;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_DESC && take && byte_in[7:6] == 2'b00)
    |=> ##1 done_out && value_out[5:0] == $past(byte_in[5:0], 2) && value_out[31:6] == 26'h0;
  endproperty
  a_lit_pos: assert property (p_lit_pos) else $error("positive literal wrong"); // [RQ16]

  property p_lit_neg;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_DESC && take && byte_in[7:4] == 4'hf)
    |=> ##1 done_out && value_out[31:4] == 28'hfffffff &&
    value_out[3:0] == $past(byte_in[3:0], 2) &&
    bytes_used_out == (expanded_out ? 3'h2 : 3'h1);
  endproperty
  a_lit_neg: assert property (p_lit_neg) else $error("negative literal wrong"); // [RQ13]

  property p_no_desc;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_IDLE && start_in && no_desc_in)
    |=> done_out && bytes_used_out == 3'h0 && kind_out == operand_decoder_pkg::K_NONE;
  endproperty
  a_no_desc: assert property (p_no_desc) else $error("descriptor-less operand wrong"); // [RQ4]

  property p_fp_sel;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_DESC && take && byte_in[7:4] == 4'h6 &&
     byte_in[3:0] != 4'hf) |=> reg_sel_out == 4'h9;
  endproperty
  a_fp_sel: assert property (p_fp_sel) else $error("frame pointer not selected"); // [RQ9]

  property p_reg_mode;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_CALC && mode == 4'h4 && !esc)
    |=> kind_out == operand_decoder_pkg::K_REG && value_out == $past(reg_data_in) && !mem_rd_out;
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register mode wrong"); // [RQ5]

  property p_regdef;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_CALC && mode == 4'h5 && !esc)
    |=> kind_out == operand_decoder_pkg::K_MEM && value_out == $past(reg_data_in);
  endproperty
  a_regdef: assert property (p_regdef) else $error("register deferred wrong"); // [RQ6]

  property p_ptr_read;
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(mem_rd_out) |-> state == operand_decoder_pkg::ST_PTR &&
      (mode == 4'h9 || mode == 4'hb || mode == 4'hd || (mode == 4'he && esc));
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read in wrong mode"); // [RQ10]

  property p_ptr_done;
    @(posedge clk_in) disable iff (sys_rst_in)
    (mem_rd_out && mem_ack_in) |=> done_out && value_out == $past(mem_data_in) && !mem_rd_out;
  endproperty
  a_ptr_done: assert property (p_ptr_done) else $error("pointer word not used"); // [RQ15]

  property p_imm_word;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state == operand_decoder_pkg::ST_DESC && take && byte_in == 8'h4f)
    |=> state == operand_decoder_pkg::ST_DATA && remaining == 3'h4;
  endproperty
  a_imm_word: assert property (p_imm_word) else $error("word immediate length wrong"); // [RQ11]

endmodule : operand_decoder

`default_nettype wire

// [tb/stream_mem_model.sv]
// Purpose: Far-side model: byte stream, register file and pointer memory
// Assumes: Bench queues stream bytes with push before each start
// Notes: Released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none

module stream_mem_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic byte_ready_in,
  input wire logic [3:0] reg_sel_in,
  input wire logic mem_rd_in,
  input wire logic [31:0] mem_addr_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic [31:0] reg_data_out,
  output logic mem_ack_out,
  output logic [31:0] mem_data_out
);
  logic [7:0] q[$];
  logic took;
  logic tick;
  logic served;
  logic [31:0] last_addr;
  int wait_cnt;

  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  // Register file contents follow the number, so a wrong select shows
  assign reg_data_out = 32'h2000_0ff0 + {12'h000, reg_sel_in, 16'h0000};

  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
    mem_ack_out = 1'b0;
    mem_data_out = 32'h0000_0000;
    took = 1'b0;
    tick = 1'b0;
    served = 1'b0;
    wait_cnt = 0;
  end

  always @(posedge clk_in) took <= byte_valid_out && byte_ready_in;

  // Byte held until taken; slow mode stalls every other cycle
  always @(negedge clk_in) begin
    if (sys_rst_in) begin
      q.delete();
      byte_valid_out = 1'b0;
    end else begin
      if (took) void'(q.pop_front());
      // Valid is written at most once per edge
      if (byte_valid_out && !took) begin
        byte_valid_out = 1'b1;
      end else if (q.size() > 0 && (!slow_in || tick)) begin
        byte_valid_out = 1'b1;
        byte_out = q[0];
      end else if (byte_valid_out) begin
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
      end
      tick = ~tick;
    end
  end

  // Pointer reads: one ack pulse per request, later when slow
  always @(negedge clk_in) begin
    if (sys_rst_in || mem_ack_out) begin
      mem_ack_out = 1'b0;
      mem_data_out = ~mem_data_out;
      wait_cnt = 0;
    end else if (mem_rd_in && !served) begin
      wait_cnt++;
      if (wait_cnt >= (slow_in ? 6 : 1)) begin
        mem_ack_out = 1'b1;
        served = 1'b1;
        last_addr = mem_addr_in;
        mem_data_out = {mem_addr_in[15:0], mem_addr_in[31:16]} ^ 32'h0f0f_0f0f;
      end
    end
    if (!mem_rd_in) served = 1'b0;
  end
endmodule : stream_mem_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the operand descriptor decoder
// Assumes: Inputs change on the falling edge
// Notes: Each run queues its bytes unless descriptor-less, starts one operand and judges it; t_reset only checks reset values
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  logic no_desc_in = 1'b0;
  logic slow = 1'b0;
  logic byte_valid, byte_ready, mem_rd, mem_ack, done_out, expanded_out;
  logic [7:0] byte_val;
  logic [3:0] reg_sel, type_out;
  logic [31:0] reg_data, mem_addr, mem_data, value_out;
  logic [1:0] kind_out;
  logic [2:0] bytes_used;
  int errors = 0;
  int total_checks = 0;
  int cycles;

  always #10 clk_in = ~clk_in;

  operand_decoder #(.ADDR_W(32)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .start_in(start_in), .no_desc_in(no_desc_in), .byte_valid_in(byte_valid),
    .byte_in(byte_val), .byte_ready_out(byte_ready), .reg_sel_out(reg_sel),
    .reg_data_in(reg_data), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
    .mem_ack_in(mem_ack), .mem_data_in(mem_data), .done_out(done_out),
    .kind_out(kind_out), .value_out(value_out), .bytes_used_out(bytes_used),
    .expanded_out(expanded_out), .type_out(type_out));

  stream_mem_model model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
    .byte_ready_in(byte_ready), .reg_sel_in(reg_sel), .mem_rd_in(mem_rd),
    .mem_addr_in(mem_addr), .byte_valid_out(byte_valid), .byte_out(byte_val),
    .reg_data_out(reg_data), .mem_ack_out(mem_ack), .mem_data_out(mem_data));

  task wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Expected register and pointer contents, worked out independently
  function automatic logic [31:0] rv(input logic [3:0] n);
    rv = 32'h2000_0ff0 + (32'(n) << 16);
  endfunction : rv

  function automatic logic [31:0] ptr(input logic [31:0] a);
    ptr = {a[15:0], a[31:16]} ^ 32'h0f0f_0f0f;
  endfunction : ptr

  // Queue descriptor and data, pulse start, wait bounded for done
  task run(input logic nd, input logic [7:0] d, input logic [31:0] w, input int n,
           input logic [1:0] k, input logic [31:0] v, input logic [2:0] used);
    if (!nd) begin
      model.push(d);
      for (int i = 0; i < n; i++) model.push(w[8*i +: 8]);
    end
    @(negedge clk_in);
    start_in = 1'b1;
    no_desc_in = nd;
    @(negedge clk_in);
    start_in = 1'b0;
    no_desc_in = 1'b0;
    cycles = 1;
    while (done_out !== 1'b1 && cycles < 200) begin
      @(negedge clk_in);
      cycles++;
    end
    if (cycles >= 200) begin
      errors++;
      $display("wrong value done_out expected 1 seen %b", done_out);
      wrap_up();
    end
    check("kind_out", 32'(k), 32'(kind_out));
    check("value_out", v, value_out);
    check("bytes_used_out", 32'(used), 32'(bytes_used));
  endtask : run

  task t_reset();
    check("done_out", 32'h0, 32'(done_out));
    check("value_out", 32'h0, value_out);
    check("mem_rd_out", 32'h0, 32'(mem_rd));
    check("byte_ready_out", 32'h0, 32'(byte_ready));
  endtask : t_reset

  // Descriptor-less operand finishes at once, consuming nothing
  task t_no_desc();
    run(1'b1, 8'h00, 32'h0, 0, 2'h0, 32'h0, 3'h0);
    check("no_desc cycles", 32'h1, 32'(cycles));
  endtask : t_no_desc

  // Literal boundaries: 0, 63, -16, -1
  task t_literals();
    logic [7:0] d [4] = '{8'h00, 8'h3f, 8'hf0, 8'hff};
    logic [31:0] v [4] = '{32'h0, 32'h3f, 32'hffff_fff0, 32'hffff_ffff};
    for (int i = 0; i < 4; i++) run(1'b0, d[i], 32'h0, 0, 2'h2, v[i], 3'h1);
  endtask : t_literals

  task t_register();
    run(1'b0, 8'h40, 32'h0, 0, 2'h1, rv(4'h0), 3'h1);
    run(1'b0, 8'h4e, 32'h0, 0, 2'h1, rv(4'he), 3'h1);
    check("reg_sel_out", 32'he, 32'(reg_sel));
    run(1'b0, 8'h52, 32'h0, 0, 2'h3, rv(4'h2), 3'h1);
    run(1'b0, 8'h5c, 32'h0, 0, 2'h3, rv(4'hc), 3'h1);
  endtask : t_register

  task t_short();
    run(1'b0, 8'h63, 32'h0, 0, 2'h3, rv(4'h9) + 32'h3, 3'h1);
    run(1'b0, 8'h70, 32'h0, 0, 2'h3, rv(4'ha), 3'h1);
    run(1'b0, 8'h7e, 32'h0, 0, 2'h3, rv(4'ha) + 32'he, 3'h1);
  endtask : t_short

  // Negative offsets exercise widening; stalled stream on the way
  task t_disp();
    slow = 1'b1;
    run(1'b0, 8'h83, 32'h1234_5678, 4, 2'h3, rv(4'h3) + 32'h1234_5678, 3'h5);
    run(1'b0, 8'ha1, 32'h8000, 2, 2'h3, rv(4'h1) + 32'hffff_8000, 3'h3);
    slow = 1'b0;
    run(1'b0, 8'hc2, 32'hf0, 1, 2'h3, rv(4'h2) + 32'hffff_fff0, 3'h2);
    run(1'b0, 8'hcf, 32'h7f, 1, 2'h3, rv(4'hf) + 32'h7f, 3'h2);
  endtask : t_disp

  task t_imm();
    run(1'b0, 8'h4f, 32'h1234_5678, 4, 2'h2, 32'h1234_5678, 3'h5);
    run(1'b0, 8'h5f, 32'habcd, 2, 2'h2, 32'hffff_abcd, 3'h3);
    run(1'b0, 8'h6f, 32'h50, 1, 2'h2, 32'h50, 3'h2);
    run(1'b0, 8'h7f, 32'h8000_2e04, 4, 2'h3, 32'h8000_2e04, 3'h5);
  endtask : t_imm

  // Pointer modes: address sent out, pointer word returned as result
  task dfr(input logic [7:0] d, input logic [31:0] w, input int n, input logic [31:0] a);
    run(1'b0, d, w, n, 2'h3, ptr(a), 3'(n + 1));
    check("mem_addr_out", a, model.last_addr);
  endtask : dfr

  task t_deferred();
    dfr(8'h93, 32'h0000_0100, 4, rv(4'h3) + 32'h100);
    slow = 1'b1;
    dfr(8'hb1, 32'hfffe, 2, rv(4'h1) - 32'h2);
    slow = 1'b0;
    dfr(8'hd2, 32'h80, 1, rv(4'h2) + 32'hffff_ff80);
    dfr(8'hef, 32'h0000_2e04, 4, 32'h0000_2e04);
  endtask : t_deferred

  // Prefix recorded and counted, then cleared by a plain operand
  task t_expanded();
    model.push(8'he7);
    run(1'b0, 8'h42, 32'h0, 0, 2'h1, rv(4'h2), 3'h2);
    check("expanded_out", 32'h1, 32'(expanded_out));
    check("type_out", 32'h7, 32'(type_out));
    model.push(8'he0);
    run(1'b0, 8'h4f, 32'hdead_0001, 4, 2'h2, 32'hdead_0001, 3'h6);
    check("type_out", 32'h0, 32'(type_out));
    check("expanded_out", 32'h1, 32'(expanded_out));
    run(1'b0, 8'h01, 32'h0, 0, 2'h2, 32'h1, 3'h1);
    check("expanded_out", 32'h0, 32'(expanded_out));
    run(1'b1, 8'h00, 32'h0, 0, 2'h0, 32'h0, 3'h0);
  endtask : t_expanded

  initial begin
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_no_desc();
    t_literals();
    t_register();
    t_short();
    t_disp();
    t_imm();
    t_deferred();
    t_expanded();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
